// *** bit_sync.sv ***
// Purpose: two-flop synchroniser for slow or foreign levels
// Assumes: destination clock is core_clk
// Notes:   only the second stage may be read by other logic
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end
endmodule : bit_sync

// *** host_serial_model.sv ***
// Purpose: host controller loading divide factors over the serial port
// Assumes: link clock period 6 ns, running only inside a frame
// Notes:   words the host may never send are dropped unsent
`timescale 1ns/1ps
module host_serial_model #(
  parameter bit MODE_64 = 1'b1
) (
  // serial load port
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end

  // ==========================================================
  // one frame, then an optional latch pulse
  task automatic load_word(input logic [16:0] w, input logic latch);
    if (w[16:7] < 10'h005) return;
    if (w[16:7] <= {3'h0, w[6:0]}) return;
    if (MODE_64 && w[6]) return;
    for (int i = 16; i >= 0; i--) begin
      ser_data = w[i];
      #3 ser_clk = 1'b1;
      #3 ser_clk = 1'b0;
    end
    // released line must not look like the last bit
    ser_data = ~w[0];
    if (latch) begin
      #5 load_strobe = 1'b1;
      #48 load_strobe = 1'b0;
      // clock stays still until the copy has settled
      #30;
    end
  endtask : load_word
endmodule : host_serial_model

// *** phase_freq_detector.sv ***
// Purpose: three-state phase/frequency detector core
// Assumes: ref and div pulses are one core_clk cycle wide
// Notes:   both flags clear together, so equal edges leave no pulse
`timescale 1ns/1ps
module phase_freq_detector (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // edge pulses
  input  wire logic ref_pulse,
  input  wire logic div_pulse,
  // detector state
  output logic      up_reg,
  output logic      dn_reg
);
  logic up_next;
  logic dn_next;

  always_comb begin
    up_next = up_reg | ref_pulse;
    dn_next = dn_reg | div_pulse;
    // reset path of the classic two-flop detector
    if (up_next && dn_next) begin
      up_next = 1'b0;
      dn_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      up_reg <= up_next;
      dn_reg <= dn_next;
    end
  end
endmodule : phase_freq_detector

// *** pll_consts.svh ***
// Purpose: shared constants for the synthesizer divider loader
// Assumes: included by bare name from the loader design file only
// Notes:   offsets are byte addresses on the register bus
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// ==========================================================
// divide-factor word layout
`define PLL_WORD_W        17
`define PLL_A_W           7
`define PLL_N_W           10
`define PLL_A_LSB         0
`define PLL_N_LSB         7
`define PLL_N_MSB         16

// ==========================================================
// reference divider
`define PLL_SEL_W         3
`define PLL_REF_W         12
`define PLL_REF_RATIO_0   12'h008
`define PLL_REF_RATIO_1   12'h010
`define PLL_REF_RATIO_2   12'h040
`define PLL_REF_RATIO_3   12'h080
`define PLL_REF_RATIO_4   12'h100
`define PLL_REF_RATIO_5   12'h200
`define PLL_REF_RATIO_6   12'h400
`define PLL_REF_RATIO_7   12'h800

// ==========================================================
// register map
`define PLL_OFS_CTRL      4'h0
`define PLL_OFS_STATUS    4'h4
`define PLL_OFS_LATCH     4'h8
`define PLL_CTRL_RUN_BIT  0
`define PLL_CTRL_RESET    32'h0000_0001
`define PLL_ST_LOCK_BIT   0
`define PLL_ST_UP_BIT     1
`define PLL_ST_DN_BIT     2
`define PLL_ST_MOD_BIT    3
`define PLL_LATCH_RESET   17'h0_0000

`endif

// *** pll_loader_chk.sv ***
// Purpose: port checks for the divider loader, core_clk domain
// Assumes: serial side is judged through latch reads in the bench
// Notes:   bound into the top module at the foot of this file
`timescale 1ns/1ps
module pll_loader_chk (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                resetn,
  // synthesizer side
  input wire logic                prescaler_in,
  input wire logic                modulus_ctrl,
  input wire logic                ref_divider_output,
  input wire logic                div_output,
  input wire logic                lock_indicator,
  input wire logic                pd_oe,
  // register bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire pll_pkg::axi_resp_t  s_axi_bresp,
  input wire logic [31:0]         s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire pll_pkg::axi_resp_t  s_axi_rresp
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================================
  // dividers and detector
  a_div_pulse: assert property (div_output |=> !div_output)
    else $error("divider pulse wider than one cycle");
  a_ref_pulse: assert property (ref_divider_output |=>
    !ref_divider_output)
    else $error("reference pulse wider than one cycle");
  a_mod_on_fall: assert property ($changed(modulus_ctrl) |->
    !$past(prescaler_in) && !$past(prescaler_in, 2))
    else $error("modulus changed away from a falling edge");
  a_lock_drive: assert property (pd_oe |-> !lock_indicator)
    else $error("lock high while detector drives");

  // ==========================================================
  // register bus
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_bad_addr: assert property (s_axi_arvalid && s_axi_arready &&
    !(s_axi_araddr[3:0] inside {4'h0, 4'h4, 4'h8}) |=>
    s_axi_rresp == pll_pkg::resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  c_div: cover property (div_output);
  c_ref: cover property (ref_divider_output);
  c_mod_low: cover property ($fell(modulus_ctrl));
endmodule : pll_loader_chk

bind pll_synth_divider_loader pll_loader_chk chk (
  .core_clk, .resetn, .prescaler_in, .modulus_ctrl, .ref_divider_output,
  .div_output, .lock_indicator, .pd_oe, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp
);

// *** pll_pkg.sv ***
// Purpose: types shared by the divider loader design
// Assumes: pll_consts.svh holds every number but the bus response codes below
// Notes:   nothing is imported; users write pll_pkg::name
package pll_pkg;
  // ==========================================================
  // bus response codes
  typedef enum logic [1:0] {
    resp_okay   = 2'h0,
    resp_slverr = 2'h2
  } axi_resp_t;

  // ==========================================================
  // phase detector output drive
  typedef enum logic [1:0] {
    pd_float,
    pd_source,
    pd_sink
  } pd_mode_t;
endpackage : pll_pkg

// *** pll_synth_divider_loader.sv ***
// Purpose: digital core of a pulse-swallow synthesizer with serial load
// Assumes: host holds ser_clk still while load_strobe is high
// Notes:   osc and prescaler inputs are oversampled by core_clk
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_synth_divider_loader (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // serial load port
  input  wire logic                   ser_clk,
  input  wire logic                   ser_data,
  input  wire logic                   load_strobe,
  // reference select pins
  input  wire logic                   ref_ratio_sel_0,
  input  wire logic                   ref_ratio_sel_1,
  input  wire logic                   ref_ratio_sel_2,
  // oscillator and prescaler
  input  wire logic                   osc_input,
  input  wire logic                   prescaler_in,
  output logic                        modulus_ctrl,
  // synthesizer outputs
  output logic                        ref_divider_output,
  output logic                        div_output,
  output logic                        lock_indicator,
  output logic                        pd_out,
  output logic                        pd_oe,
  // axi4-lite write address
  input  wire logic [31:0]            s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  // axi4-lite write response
  output pll_pkg::axi_resp_t          s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0]            s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output pll_pkg::axi_resp_t          s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  // ==========================================================
  // declarations
  logic [`PLL_WORD_W-1:0] shift_reg;
  logic [`PLL_WORD_W-1:0] latch_reg;
  logic                   strobe_s;
  logic [`PLL_SEL_W-1:0]  sel_s;
  logic                   osc_s;
  logic                   osc_prev_reg;
  logic                   fin_s;
  logic                   fin_prev_reg;
  logic                   osc_rise;
  logic                   fin_rise;
  logic                   fin_fall;
  logic [`PLL_REF_W-1:0]  ref_ratio;
  logic [`PLL_REF_W-1:0]  ref_cnt_reg;
  logic                   ref_pulse_reg;
  logic [`PLL_A_W-1:0]    swallow_a;
  logic [`PLL_N_W-1:0]    prog_n;
  logic [`PLL_A_W-1:0]    a_cnt_reg;
  logic [`PLL_N_W-1:0]    n_cnt_reg;
  logic                   div_pulse_reg;
  logic                   pfd_up;
  logic                   pfd_dn;
  pll_pkg::pd_mode_t      pd_mode;
  logic [31:0]            ctrl_reg;
  logic                   run;
  logic                   aw_got_reg;
  logic                   w_got_reg;
  logic [3:0]             awaddr_reg;
  logic [31:0]            wdata_reg;
  logic [3:0]             wstrb_reg;
  logic [31:0]            status_word;

  // ==========================================================
  // serial shift register, link clock domain
  // host owns ser_clk; it may stand still between words
  always_ff @(posedge ser_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= {shift_reg[`PLL_WORD_W-2:0], ser_data};
    end
  end

  // ==========================================================
  // input synchronisers
  bit_sync #(.W(1)) u_sync_strobe (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (load_strobe),
    .sync_out (strobe_s)
  );

  bit_sync #(.W(`PLL_SEL_W)) u_sync_sel (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in ({ref_ratio_sel_2, ref_ratio_sel_1, ref_ratio_sel_0}),
    .sync_out (sel_s)
  );

  bit_sync #(.W(1)) u_sync_osc (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (osc_input),
    .sync_out (osc_s)
  );

  bit_sync #(.W(1)) u_sync_fin (
    .core_clk (core_clk),
    .resetn   (resetn),
    .async_in (prescaler_in),
    .sync_out (fin_s)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev_reg <= 1'b0;
      fin_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg <= osc_s;
      fin_prev_reg <= fin_s;
    end
  end

  assign osc_rise = osc_s & ~osc_prev_reg;
  assign fin_rise = fin_s & ~fin_prev_reg;
  assign fin_fall = ~fin_s & fin_prev_reg;

  // ==========================================================
  // factor latch
  // strobe gates the word across: shift_reg is quiet while it is high,
  // so the multi-bit copy needs no further crossing logic
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= `PLL_LATCH_RESET;
    end else if (strobe_s) begin
      latch_reg <= shift_reg;
    end
  end

  // dividers read only the latch, never the shifting word
  assign swallow_a = latch_reg[`PLL_A_LSB +: `PLL_A_W];
  assign prog_n    = latch_reg[`PLL_N_MSB:`PLL_N_LSB];

  // ==========================================================
  // reference divider
  always_comb begin
    case (sel_s)
      3'h0:    ref_ratio = `PLL_REF_RATIO_0;
      3'h1:    ref_ratio = `PLL_REF_RATIO_1;
      3'h2:    ref_ratio = `PLL_REF_RATIO_2;
      3'h3:    ref_ratio = `PLL_REF_RATIO_3;
      3'h4:    ref_ratio = `PLL_REF_RATIO_4;
      3'h5:    ref_ratio = `PLL_REF_RATIO_5;
      3'h6:    ref_ratio = `PLL_REF_RATIO_6;
      default: ref_ratio = `PLL_REF_RATIO_7;
    endcase
  end

  assign run = ctrl_reg[`PLL_CTRL_RUN_BIT];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ref_cnt_reg   <= '0;
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= 1'b0;
      if (!run) begin
        ref_cnt_reg <= '0;
      end else if (osc_rise) begin
        // >= so a ratio change mid-count cannot overrun
        if (ref_cnt_reg >= ref_ratio - 12'h001) begin
          ref_cnt_reg   <= '0;
          ref_pulse_reg <= 1'b1;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + 12'h001;
        end
      end
    end
  end

  // ==========================================================
  // pulse-swallow programmable divider
  // counts prescaler rising edges; N below 2 degenerates to every edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      n_cnt_reg     <= '0;
      a_cnt_reg     <= '0;
      div_pulse_reg <= 1'b0;
    end else begin
      div_pulse_reg <= 1'b0;
      if (!run) begin
        n_cnt_reg <= prog_n;
        a_cnt_reg <= swallow_a;
      end else if (fin_rise) begin
        if (n_cnt_reg <= 10'h001) begin
          n_cnt_reg     <= prog_n;
          a_cnt_reg     <= swallow_a;
          div_pulse_reg <= 1'b1;
        end else begin
          n_cnt_reg <= n_cnt_reg - 10'h001;
          if (a_cnt_reg != '0) begin
            a_cnt_reg <= a_cnt_reg - 7'h01;
          end
        end
      end
    end
  end

  // modulus: low (base+1) while swallowing, high (base) afterwards
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      modulus_ctrl <= 1'b1;
    end else if (fin_fall) begin
      modulus_ctrl <= (a_cnt_reg == '0);
    end
  end

  // ==========================================================
  // phase detector and lock
  phase_freq_detector u_pfd (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .ref_pulse (ref_pulse_reg),
    .div_pulse (div_pulse_reg),
    .up_reg    (pfd_up),
    .dn_reg    (pfd_dn)
  );

  always_comb begin
    if (pfd_up) begin
      pd_mode = pll_pkg::pd_source;
    end else if (pfd_dn) begin
      pd_mode = pll_pkg::pd_sink;
    end else begin
      pd_mode = pll_pkg::pd_float;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pd_out         <= 1'b0;
      pd_oe          <= 1'b0;
      lock_indicator <= 1'b1;
    end else begin
      case (pd_mode)
        pll_pkg::pd_source: begin
          pd_out <= 1'b1;
          pd_oe  <= 1'b1;
        end
        pll_pkg::pd_sink: begin
          pd_out <= 1'b0;
          pd_oe  <= 1'b1;
        end
        default: begin
          pd_out <= 1'b0;
          pd_oe  <= 1'b0;
        end
      endcase
      // any residual phase error shows as a low-going pulse
      lock_indicator <= ~(pfd_up | pfd_dn);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ref_divider_output <= 1'b0;
      div_output         <= 1'b0;
    end else begin
      ref_divider_output <= ref_pulse_reg;
      div_output         <= div_pulse_reg;
    end
  end

  // ==========================================================
  // axi4-lite write path
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      aw_got_reg    <= 1'b0;
      awaddr_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got_reg    <= 1'b1;
      awaddr_reg    <= s_axi_awaddr[3:0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end else if (aw_got_reg && w_got_reg) begin
      aw_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_wready <= 1'b1;
      w_got_reg    <= 1'b0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got_reg    <= 1'b1;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end else if (aw_got_reg && w_got_reg) begin
      w_got_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pll_pkg::resp_okay;
    end else if (aw_got_reg && w_got_reg) begin
      s_axi_bvalid <= 1'b1;
      case (awaddr_reg)
        `PLL_OFS_CTRL, `PLL_OFS_STATUS, `PLL_OFS_LATCH: begin
          s_axi_bresp <= pll_pkg::resp_okay;
        end
        default: begin
          s_axi_bresp <= pll_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only the run bit is writable; status and latch ignore writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `PLL_CTRL_RESET;
    end else if (aw_got_reg && w_got_reg &&
                 awaddr_reg == `PLL_OFS_CTRL && wstrb_reg[0]) begin
      ctrl_reg <= {31'h0000_0000, wdata_reg[`PLL_CTRL_RUN_BIT]};
    end
  end

  // ==========================================================
  // axi4-lite read path
  always_comb begin
    status_word = '0;
    status_word[`PLL_ST_LOCK_BIT] = lock_indicator;
    status_word[`PLL_ST_UP_BIT]   = pfd_up;
    status_word[`PLL_ST_DN_BIT]   = pfd_dn;
    status_word[`PLL_ST_MOD_BIT]  = modulus_ctrl;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pll_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= pll_pkg::resp_okay;
      case (s_axi_araddr[3:0])
        `PLL_OFS_CTRL:   s_axi_rdata <= ctrl_reg;
        `PLL_OFS_STATUS: s_axi_rdata <= status_word;
        `PLL_OFS_LATCH:  s_axi_rdata <= {15'h0000, latch_reg};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= pll_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : pll_synth_divider_loader

// *** pll_synth_divider_loader_tb.sv ***
// Purpose: self-checking bench for the divider loader
// Assumes: osc and prescaler toggle every 4 core_clk cycles
// Notes:   reference ratios measured on the second interval
`timescale 1ns/1ps
module pll_synth_divider_loader_tb;
  // ==========================================================
  // stimulus and observation
  localparam pll_pkg::axi_resp_t ok = pll_pkg::resp_okay;
  localparam pll_pkg::axi_resp_t slv = pll_pkg::resp_slverr;
  logic               core_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               osc_input = 1'b0;
  logic               prescaler_in = 1'b0;
  logic [2:0]         sel = 3'h0;
  logic               run_o = 1'b0;
  logic               run_p = 1'b0;
  logic [31:0]        s_axi_awaddr = 32'h0;
  logic [31:0]        s_axi_wdata = 32'h0;
  logic [31:0]        s_axi_araddr = 32'h0;
  logic               s_axi_awvalid = 1'b0;
  logic               s_axi_wvalid = 1'b0;
  logic               s_axi_bready = 1'b0;
  logic               s_axi_arvalid = 1'b0;
  logic               s_axi_rready = 1'b0;
  wire                ser_clk, ser_data, load_strobe, modulus_ctrl;
  wire                ref_divider_output, div_output, lock_indicator;
  wire                pd_out, pd_oe, s_axi_awready, s_axi_wready;
  wire                s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [31:0]         s_axi_rdata;
  pll_pkg::axi_resp_t s_axi_bresp, s_axi_rresp;
  logic [2:0]         cnt = 3'h0;
  logic [11:0]        o_rise = 12'h0, r_seen = 12'h0;
  logic [9:0]         p_rise = 10'h0, p_low = 10'h0, n_seen = 10'h0;
  logic [9:0]         a_seen = 10'h0;
  logic [11:0]        rr [8] = '{12'h008, 12'h010, 12'h040, 12'h080,
                                 12'h100, 12'h200, 12'h400, 12'h800};
  logic [16:0]        dw [3] = '{17'h00503, 17'h00280, 17'h00284};
  int                 num_errors = 0;
  int                 checked = 0;
  int                 cycles = 0;

  pll_synth_divider_loader dut (
    .core_clk, .resetn, .ser_clk, .ser_data, .load_strobe,
    .ref_ratio_sel_0(sel[0]), .ref_ratio_sel_1(sel[1]),
    .ref_ratio_sel_2(sel[2]), .osc_input, .prescaler_in, .modulus_ctrl,
    .ref_divider_output, .div_output, .lock_indicator, .pd_out, .pd_oe,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  host_serial_model host (.ser_clk, .ser_data, .load_strobe);

  always #4 core_clk = ~core_clk;

  // ==========================================================
  // edge sources and interval counters
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    cnt <= cnt + 3'h1;
    osc_input <= cnt[2] & run_o;
    prescaler_in <= cnt[2] & run_p;
    if (cnt == 3'h4 && run_o) o_rise <= o_rise + 12'h1;
    if (cnt == 3'h4 && run_p) p_rise <= p_rise + 10'h1;
    if (cnt == 3'h4 && run_p && !modulus_ctrl) p_low <= p_low + 10'h1;
    if (div_output) begin
      n_seen <= p_rise;
      a_seen <= p_low;
      p_rise <= 10'h0;
      p_low <= 10'h0;
    end
    if (ref_divider_output) begin
      r_seen <= o_rise;
      o_rise <= 12'h0;
    end
    if (cycles == 80000) begin
      num_errors++;
      stop_test();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t ns: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1 && !aw_ok) s_axi_awvalid <= 1'b0;
      if (s_axi_awready === 1'b1) aw_ok = 1'b1;
      if (s_axi_wready === 1'b1 && !w_ok) s_axi_wvalid <= 1'b0;
      if (s_axi_wready === 1'b1) w_ok = 1'b1;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    // late ready: the response has to wait for it
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    chk(32'(s_axi_bresp), 32'(ok), "write response");
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, exp, input pll_pkg::axi_resp_t er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    // late ready: read data has to stand for a stalled cycle
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    chk(s_axi_rdata, exp, "read data");
    chk(32'(s_axi_rresp), 32'(er), "read response");
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // test sequence
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rd(32'h0, 32'h1, ok);
    rd(32'h4, 32'h9, ok);
    rd(32'h8, 32'h0, ok);
    rd(32'hc, 32'h0, slv);
    wr(32'h4, 32'hf);
    rd(32'h4, 32'h9, ok);
    wr(32'h0, 32'h0);
    rd(32'h0, 32'h0, ok);
    wr(32'h0, 32'h1);
    $display("register test done");
    host.load_word(17'h00503, 1'b1);
    @(posedge core_clk);
    rd(32'h8, 32'h503, ok);
    host.load_word(17'h00a05, 1'b0);
    @(posedge core_clk);
    rd(32'h8, 32'h503, ok);
    $display("serial load test done");
    run_p <= 1'b1;
    foreach (dw[i]) begin
      host.load_word(dw[i], 1'b1);
      repeat (3) @(posedge div_output);
      repeat (2) @(posedge core_clk);
      chk(32'(n_seen), 32'(dw[i][16:7]), "count N");
      chk(32'(a_seen), 32'(dw[i][6:0]), "count A");
    end
    chk(32'({pd_oe, pd_out, lock_indicator}), 32'h4, "sink");
    $display("divider test done");
    // prescaler quiet so reference pulses leave the detector sourcing
    run_p <= 1'b0;
    run_o <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(32'h0, 32'h0);
      sel <= 3'(c);
      wr(32'h0, 32'h1);
      repeat (2) @(posedge ref_divider_output);
      repeat (2) @(posedge core_clk);
      chk(32'(r_seen), 32'(rr[c]), "reference ratio");
    end
    chk(32'({pd_oe, pd_out, lock_indicator}), 32'h6, "source");
    $display("reference test done");
    stop_test();
  end
endmodule : pll_synth_divider_loader_tb
